// ---- rtl/cpmc_top.sv ----
`default_nettype none
module cpmc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic video_clock_in_i,
    input wire logic [3:0] video_data_lanes_i,
    input wire logic power_down_n_i,
    input wire logic output_swing_sel_i,
    input wire logic deemphasis_ctrl_i,
    input wire logic input_bit_map_sel_i,
    input wire logic self_test_en_i,
    input wire logic [1:0] op_mode_sel_i,
    input wire logic [2:0] bus_addr_sel_i,
    input wire logic [7:0] reserved_inputs_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic dout_p_o,
    output logic dout_n_o,
    output logic pll_en_o,
    output logic swing_large_o,
    output logic deemph_en_o,
    output logic map_msb_o,
    output logic self_test_o,
    output logic filter_en_o,
    output logic [1:0] compat_mode_o,
    output logic [6:0] bus_addr_o
);
    // ----------------------------------------
    // system domain state
    // ----------------------------------------
    typedef struct packed {
        logic pd_s1;
        logic pd_s2;
        logic [8:0] strap_s1;
        logic [8:0] strap_s2;
        logic ser_s1;
        logic ser_s2;
        logic [1:0] bus_s1;
        logic [1:0] bus_s2;
        cpmc_pkg::cpmc_pstate_t state;
        logic [8:0] strap;
        logic [4:0] ctrl;
        logic [31:0] rdata;
        logic dout_p;
        logic dout_n;
        logic pll_en;
        logic swing;
        logic deemph;
        logic map;
        logic bist;
        logic filter;
        logic [1:0] mode;
        logic [6:0] bus_addr;
        logic sda_oe;
    } cpmc_sys_t;

    // ----------------------------------------
    // link domain state
    // ----------------------------------------
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic run_s1;
        logic run_s2;
        logic map_s1;
        logic map_s2;
        logic bist_s1;
        logic bist_s2;
        logic [3:0] word;
        logic [1:0] cnt;
        logic [6:0] lfsr;
        logic ser;
    } cpmc_link_t;

    cpmc_sys_t s;
    cpmc_sys_t next_s;
    cpmc_link_t l;
    cpmc_link_t next_l;
    logic run;
    logic [8:0] straps_in;
    logic [3:0] mapped;

    assign run = (s.state == cpmc_pkg::CPMC_PS_RUN);
    assign straps_in = {bus_addr_sel_i, op_mode_sel_i, self_test_en_i, input_bit_map_sel_i,
                        deemphasis_ctrl_i, output_swing_sel_i};

    // ----------------------------------------
    // system domain next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.pd_s1 = power_down_n_i;
        next_s.pd_s2 = s.pd_s1;
        next_s.strap_s1 = straps_in;
        next_s.strap_s2 = s.strap_s1;
        next_s.ser_s1 = l.ser;
        next_s.ser_s2 = s.ser_s1;
        next_s.bus_s1 = {sda_i, scl_i};
        next_s.bus_s2 = s.bus_s1;
        next_s.rdata = 32'h0000_0000;
        case (s.state)
            cpmc_pkg::CPMC_PS_DOWN: begin
                next_s.ctrl = cpmc_pkg::CTRL_RST;
                if (s.pd_s2) begin
                    next_s.state = cpmc_pkg::CPMC_PS_WAKE;
                end
            end
            cpmc_pkg::CPMC_PS_WAKE: begin
                next_s.strap = s.strap_s2;
                next_s.state = s.pd_s2 ? cpmc_pkg::CPMC_PS_RUN : cpmc_pkg::CPMC_PS_DOWN;
            end
            cpmc_pkg::CPMC_PS_RUN: begin
                if (!s.pd_s2) begin
                    next_s.state = cpmc_pkg::CPMC_PS_DOWN;
                end else if (wr_i && addr_i == cpmc_pkg::CTRL_OFF) begin
                    next_s.ctrl = wdata_i[4:0];
                end
            end
            default: begin
                next_s.state = cpmc_pkg::CPMC_PS_DOWN;
            end
        endcase
        if (rd_i) begin
            case (addr_i)
                cpmc_pkg::CTRL_OFF: next_s.rdata = {27'h000_0000, s.ctrl};
                cpmc_pkg::STAT_OFF: next_s.rdata = {22'h00_0000, s.bus_s2, s.mode, s.filter, s.bist,
                                                    s.map, s.deemph, s.swing, run};
                cpmc_pkg::BUSADDR_OFF: next_s.rdata = {25'h000_0000, s.bus_addr};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        // serial pair: both high unless running
        next_s.dout_p = run ? s.ser_s2 : 1'b1;
        next_s.dout_n = run ? ~s.ser_s2 : 1'b1;
        next_s.pll_en = run;
        next_s.swing = s.ctrl[cpmc_pkg::CTRL_OVR_SWING] ? s.ctrl[cpmc_pkg::CTRL_SWING]
                     : s.strap[cpmc_pkg::STRAP_SWING];
        // pin reads high when floating, which leaves de-emphasis off unless CTRL_DEEMPH is set in the control register
        next_s.deemph = ~s.strap[cpmc_pkg::STRAP_DEEMPH] | s.ctrl[cpmc_pkg::CTRL_DEEMPH];
        next_s.map = s.ctrl[cpmc_pkg::CTRL_OVR_MAP] ? s.ctrl[cpmc_pkg::CTRL_MAP]
                   : s.strap[cpmc_pkg::STRAP_MAP];
        next_s.bist = run & s.strap[cpmc_pkg::STRAP_BIST];
        next_s.mode = s.strap[cpmc_pkg::STRAP_MODE +: 2];
        next_s.filter = (s.strap[cpmc_pkg::STRAP_MODE +: 2] == cpmc_pkg::CPMC_MODE_FILT);
        next_s.bus_addr = cpmc_pkg::BUS_ADDR_BASE + {4'h0, s.strap[cpmc_pkg::STRAP_ADDR +: 3]};
        // the device never pulls the data line in this block; far side owns pull-up and clock
        next_s.sda_oe = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.state <= cpmc_pkg::CPMC_PS_DOWN;
            s.dout_p <= 1'b1;
            s.dout_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // link domain: lane mapping and serial shifter
    // ----------------------------------------
    for (genvar gi = 0; gi < cpmc_pkg::LANES; gi++) begin : g_map
        assign mapped[gi] = l.map_s2 ? video_data_lanes_i[gi] : video_data_lanes_i[cpmc_pkg::LANES - 1 - gi];
    end

    always_comb begin
        next_l = l;
        next_l.rst_s1 = rst_i;
        next_l.rst_s2 = l.rst_s1;
        next_l.run_s1 = run;
        next_l.run_s2 = l.run_s1;
        next_l.map_s1 = s.map;
        next_l.map_s2 = l.map_s1;
        next_l.bist_s1 = s.bist;
        next_l.bist_s2 = l.bist_s1;
        if (l.rst_s2 || !l.run_s2) begin
            next_l.word = 4'h0;
            next_l.cnt = 2'h0;
            next_l.lfsr = cpmc_pkg::LFSR_SEED;
            next_l.ser = 1'b0;
        end else begin
            next_l.cnt = l.cnt + 2'h1;
            if (l.cnt == 2'h0) begin
                // self-test sends a pseudo-random nibble in place of video
                next_l.word = l.bist_s2 ? l.lfsr[3:0] : mapped;
                next_l.lfsr = {l.lfsr[5:0], l.lfsr[6] ^ l.lfsr[5]};
            end else begin
                next_l.word = {l.word[2:0], 1'b0};
            end
            next_l.ser = l.word[3];
        end
    end

    always_ff @(posedge video_clock_in_i) begin
        l <= next_l;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = s.rdata;
    assign dout_p_o = s.dout_p;
    assign dout_n_o = s.dout_n;
    assign pll_en_o = s.pll_en;
    assign swing_large_o = s.swing;
    assign deemph_en_o = s.deemph;
    assign map_msb_o = s.map;
    assign self_test_o = s.bist;
    assign filter_en_o = s.filter;
    assign compat_mode_o = s.mode;
    assign bus_addr_o = s.bus_addr;
    assign sda_oe_o = s.sda_oe;
    assign sda_o = 1'b0;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_wake_up;
        s.state == cpmc_pkg::CPMC_PS_DOWN && s.pd_s2 ##1 s.state == cpmc_pkg::CPMC_PS_WAKE && s.pd_s2;
    endsequence

    sequence s_run_up;
        s.state == cpmc_pkg::CPMC_PS_RUN ##1 pll_en_o;
    endsequence

    property p_wake_to_run;
        @(posedge clk_i) disable iff (rst_i)
        s_wake_up |=> s_run_up;
    endproperty

    a_wake_to_run: assert property (p_wake_to_run)
        else $error("no run after power-down released");

    a_pd_enter_down: assert property (@(posedge clk_i) disable iff (rst_i)
        run && !s.pd_s2 |=> s.state == cpmc_pkg::CPMC_PS_DOWN ##1 !pll_en_o)
        else $error("power-down not entered");

    a_down_lines_high: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == cpmc_pkg::CPMC_PS_DOWN |=> dout_p_o && dout_n_o && !pll_en_o)
        else $error("serial lines not high while down");

    a_down_ctrl_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == cpmc_pkg::CPMC_PS_DOWN |=> s.ctrl == cpmc_pkg::CTRL_RST)
        else $error("control not cleared while down");

    a_swing_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        run && !s.ctrl[cpmc_pkg::CTRL_OVR_SWING] && $stable(s.ctrl) ##1 run && $stable(s.strap)
        |-> swing_large_o == s.strap[cpmc_pkg::STRAP_SWING])
        else $error("swing does not follow pin");

    a_swing_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        run && wr_i && addr_i == cpmc_pkg::CTRL_OFF && wdata_i[cpmc_pkg::CTRL_OVR_SWING] && s.pd_s2
        |=> ##1 swing_large_o == $past(wdata_i[cpmc_pkg::CTRL_SWING], 2))
        else $error("swing register override lost");

    a_deemph_float: assert property (@(posedge clk_i) disable iff (rst_i)
        s.strap[cpmc_pkg::STRAP_DEEMPH] && !s.ctrl[cpmc_pkg::CTRL_DEEMPH] |=> !deemph_en_o)
        else $error("de-emphasis on with floating pin");

    a_map_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.ctrl[cpmc_pkg::CTRL_OVR_MAP] |=> map_msb_o == $past(s.strap[cpmc_pkg::STRAP_MAP]))
        else $error("map select wrong");

    a_mode_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> filter_en_o == ($past(s.strap[cpmc_pkg::STRAP_MODE +: 2]) == 2'b01)
        && compat_mode_o == $past(s.strap[cpmc_pkg::STRAP_MODE +: 2]))
        else $error("mode decode wrong");

    a_bist_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        !run |=> !self_test_o)
        else $error("self-test active while down");

    a_addr_strap: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> bus_addr_o == cpmc_pkg::BUS_ADDR_BASE + {4'h0, $past(s.strap[cpmc_pkg::STRAP_ADDR +: 3])})
        else $error("bus address wrong");

    a_sda_release: assert property (@(posedge clk_i) disable iff (rst_i)
        !sda_oe_o && !sda_o)
        else $error("data line driven");

    a_straps_held: assert property (@(posedge clk_i) disable iff (rst_i)
        run && $past(run) |-> $stable(s.strap))
        else $error("straps changed while running");

    a_read_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        run && s.pd_s2 && wr_i && addr_i == cpmc_pkg::CTRL_OFF |=> s.ctrl == $past(wdata_i[4:0]))
        else $error("control write lost");

    a_write_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        !run && wr_i |=> s.ctrl == cpmc_pkg::CTRL_RST)
        else $error("control written while down");

    a_read_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == cpmc_pkg::CTRL_OFF |=> rdata_o == {27'h000_0000, $past(s.ctrl)})
        else $error("control read wrong");

    a_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == cpmc_pkg::STAT_OFF |=> rdata_o[cpmc_pkg::STAT_RUN] == $past(run)
        && rdata_o[cpmc_pkg::STAT_SCL +: 2] == $past(s.bus_s2))
        else $error("status read wrong");

    a_strap_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == cpmc_pkg::CPMC_PS_WAKE |=> s.strap == $past(s.strap_s2))
        else $error("straps not taken on wake");

    a_down_stays: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == cpmc_pkg::CPMC_PS_DOWN && !s.pd_s2 |=> s.state == cpmc_pkg::CPMC_PS_DOWN)
        else $error("left power-down too early");

    a_pair_opposite: assert property (@(posedge clk_i) disable iff (rst_i)
        run |=> dout_n_o != dout_p_o)
        else $error("serial pair not complementary");

    a_bist_on: assert property (@(posedge clk_i) disable iff (rst_i)
        run && s.strap[cpmc_pkg::STRAP_BIST] |=> self_test_o)
        else $error("self-test not entered");

    a_deemph_on: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.strap[cpmc_pkg::STRAP_DEEMPH] || s.ctrl[cpmc_pkg::CTRL_DEEMPH] |=> deemph_en_o)
        else $error("de-emphasis not enabled");

    a_swing_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
        s.ctrl[cpmc_pkg::CTRL_OVR_SWING] |=> swing_large_o == $past(s.ctrl[cpmc_pkg::CTRL_SWING]))
        else $error("swing override wrong");

    a_map_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        s.ctrl[cpmc_pkg::CTRL_OVR_MAP] |=> map_msb_o == $past(s.ctrl[cpmc_pkg::CTRL_MAP]))
        else $error("map override wrong");

    sequence s_link_live;
        !l.rst_s2 && l.run_s2;
    endsequence

    sequence s_link_shift;
        !l.rst_s2 && l.run_s2 && l.cnt != 2'h0;
    endsequence

    a_link_idle: assert property (@(posedge video_clock_in_i) disable iff (l.rst_s2)
        !l.run_s2 |=> !l.ser)
        else $error("link sends while down");

    a_link_shift: assert property (@(posedge video_clock_in_i) disable iff (l.rst_s2)
        s_link_shift |=> l.word[3:1] == $past(l.word[2:0]))
        else $error("serial word not shifted");

    a_lfsr_live: assert property (@(posedge video_clock_in_i) disable iff (l.rst_s2)
        s_link_live |-> l.lfsr != 7'h00)
        else $error("self-test pattern stuck at zero");

endmodule // cpmc_top
`default_nettype wire

// ---- rtl/cpmc_pkg.sv ----
`default_nettype none
package cpmc_pkg;
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] STAT_OFF = 4'h4;
    localparam logic [3:0] BUSADDR_OFF = 4'h8;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // control register fields
    localparam int CTRL_SWING = 0;
    localparam int CTRL_DEEMPH = 1;
    localparam int CTRL_MAP = 2;
    localparam int CTRL_OVR_SWING = 3;
    localparam int CTRL_OVR_MAP = 4;
    localparam int CTRL_W = 5;
    // status register fields
    localparam int STAT_RUN = 0;
    localparam int STAT_SWING = 1;
    localparam int STAT_DEEMPH = 2;
    localparam int STAT_MAP = 3;
    localparam int STAT_BIST = 4;
    localparam int STAT_FILTER = 5;
    localparam int STAT_MODE = 6;
    localparam int STAT_SCL = 8;
    localparam int STAT_SDA = 9;
    // ----------------------------------------
    // strap word layout
    // ----------------------------------------
    localparam int STRAP_SWING = 0;
    localparam int STRAP_DEEMPH = 1;
    localparam int STRAP_MAP = 2;
    localparam int STRAP_BIST = 3;
    localparam int STRAP_MODE = 4;
    localparam int STRAP_ADDR = 6;
    localparam int STRAP_W = 9;
    // base of the serial control bus address; value is arbitrary
    localparam logic [6:0] BUS_ADDR_BASE = 7'h30;
    // ----------------------------------------
    // link side
    // ----------------------------------------
    localparam int LANES = 4;
    localparam logic [6:0] LFSR_SEED = 7'h7f;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CPMC_MODE_NOFILT = 2'b00,
        CPMC_MODE_FILT = 2'b01,
        CPMC_MODE_OLD_A = 2'b10,
        CPMC_MODE_OLD_B = 2'b11
    } cpmc_mode_t;
    typedef enum logic [2:0] {
        CPMC_PS_DOWN = 3'b001,
        CPMC_PS_WAKE = 3'b010,
        CPMC_PS_RUN = 3'b100
    } cpmc_pstate_t;
endpackage
`default_nettype wire

// ---- verification/cpmc_video_src.sv ----
`default_nettype none
module cpmc_video_src (
    output logic clk_o,
    output logic [3:0] lanes_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // forwarded video clock, free running
    // ----------------------------------------
    initial begin
        clk_o = 1'b0;
        #3.3;
        forever #7.5 clk_o = ~clk_o;
    end
    // lanes move away from the capture edge; the step makes every bit toggle
    initial begin
        lanes_o = 4'h0;
        forever @(negedge clk_o) lanes_o <= lanes_o + 4'h5;
    end
endmodule // cpmc_video_src
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic video_clock_in;
    logic [3:0] lanes;
    logic pd_n = 1'b0;
    logic swing = 1'b0;
    logic deemph = 1'b1;
    logic map = 1'b0;
    logic bist = 1'b0;
    logic [1:0] mode = 2'b00;
    logic [2:0] asel = 3'h3;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sda_o, sda_oe_o, dout_p, dout_n, pll_en, swing_large, deemph_en, map_msb, self_test, filter_en;
    logic [31:0] rdata;
    logic [1:0] compat;
    logic [6:0] bus_addr;
    logic sda_w;
    int n_mismatch = 0;
    int check_count = 0;
    // open drain data line with the far side's pull-up
    assign sda_w = ~(sda_oe_o & ~sda_o);
    initial forever #2 clk_i = ~clk_i;
    cpmc_video_src i_src (.clk_o(video_clock_in), .lanes_o(lanes));
    cpmc_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .video_clock_in_i(video_clock_in), .video_data_lanes_i(lanes),
        .power_down_n_i(pd_n), .output_swing_sel_i(swing), .deemphasis_ctrl_i(deemph),
        .input_bit_map_sel_i(map), .self_test_en_i(bist), .op_mode_sel_i(mode), .bus_addr_sel_i(asel),
        .reserved_inputs_i(8'h00), .scl_i(1'b1), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dout_p_o(dout_p),
        .dout_n_o(dout_n), .pll_en_o(pll_en), .swing_large_o(swing_large), .deemph_en_o(deemph_en),
        .map_msb_o(map_msb), .self_test_o(self_test), .filter_en_o(filter_en), .compat_mode_o(compat),
        .bus_addr_o(bus_addr)
    );
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic power(input logic up);
        int i;
        @(posedge clk_i);
        pd_n <= up;
        for (i = 0; i < 20 && pll_en !== up; i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        #1;
        chk("run_state", {pll_en, dout_p & ~up, dout_n & ~up}, {up, ~up, ~up});
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [31:0] v;
        logic p;
        int m;
        int t;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("down_outs", {dout_p, dout_n, pll_en}, 3'b110);
        @(posedge clk_i);
        swing <= 1'b1;
        map <= 1'b1;
        power(1'b1);
        chk("outs", {swing_large, deemph_en, map_msb, self_test, filter_en, compat}, 7'b1010000);
        chk("bus_addr", bus_addr, cpmc_pkg::BUS_ADDR_BASE + 7'h03);
        chk("sda_oe", sda_oe_o, 1'b0);
        rd_reg(cpmc_pkg::STAT_OFF, v);
        chk("status", v, 32'h0000_030b);
        t = 0;
        p = dout_p;
        repeat (64) begin
            @(posedge clk_i);
            #1;
            if (dout_p !== p) t++;
            p = dout_p;
        end
        chk("serial_toggles", 32'(t > 4), 32'h0000_0001);
        @(posedge clk_i);
        swing <= 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        chk("swing_held", swing_large, 1'b1);
        wr_reg(cpmc_pkg::CTRL_OFF, 32'h0000_001a);
        repeat (4) @(posedge clk_i);
        #1;
        chk("reg_ctrl", {swing_large, deemph_en, map_msb}, 3'b010);
        rd_reg(cpmc_pkg::CTRL_OFF, v);
        chk("ctrl_rd", v, 32'h0000_001a);
        rd_reg(4'hc, v);
        chk("unmapped", v, 32'h0000_0000);
        power(1'b0);
        wr_reg(cpmc_pkg::CTRL_OFF, 32'h0000_001f);
        power(1'b1);
        rd_reg(cpmc_pkg::CTRL_OFF, v);
        chk("ctrl_cleared", v, 32'h0000_0000);
        chk("swing_relatch", swing_large, 1'b0);
        for (m = 0; m < 4; m++) begin
            power(1'b0);
            @(posedge clk_i);
            swing <= m[0];
            deemph <= ~m[0];
            map <= m[1];
            bist <= m[1];
            mode <= 2'(m);
            asel <= 3'(m + 4);
            power(1'b1);
            chk("mode_outs", {swing_large, deemph_en, map_msb, self_test, filter_en, compat},
                {m[0], m[0], m[1], m[1], m == 1, 2'(m)});
            chk("bus_addr", bus_addr, cpmc_pkg::BUS_ADDR_BASE + 7'(m + 4));
        end
        stop_test();
    end
    initial begin
        #40000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
